// *** rtl/dtf_tlb_fault_regs.v ***
// Data TLB register set, fault capture and formatted address
`timescale 1ns/10ps
`default_nettype none
`include "dtf_map.vh"

module dtf_tlb_fault_regs (
   input wire clk,
   input wire rst,
   input wire timeout_rst,
   input wire ipr_wr,
   input wire ipr_rd,
   input wire [3:0] ipr_idx,
   input wire [63:0] ipr_wdata,
   output reg [63:0] ipr_rdata,
   output reg ipr_rvalid,
   input wire mm_fault,
   input wire tlb_miss_flag,
   input wire ref_write,
   input wire access_violation_flag,
   input wire read_fault,
   input wire write_fault_flag,
   input wire bad_address_flag,
   input wire [4:0] fault_ra,
   input wire [5:0] fault_opcode,
   input wire [63:0] fault_va,
   input wire [3:0] parity_err,
   input wire look_req,
   input wire [29:0] look_va,
   output wire look_hit,
   output wire [63:0] look_pte,
   output reg [6:0] data_tlb_space_id_reg,
   output reg [1:0] data_tlb_mode_reg,
   output reg flat_pte_format_bit
);

   // ****************************************
   // Decode helper
   // ****************************************
   function is_reg;
      input [3:0] idx;
      input [3:0] target;
      begin
         is_reg = (idx == target);
      end
   endfunction

   wire wr_tag = ipr_wr && is_reg(ipr_idx, `DTF_IDX_TAG);
   wire wr_entry = ipr_wr && is_reg(ipr_idx, `DTF_IDX_ENTRY);
   wire wr_ptbr = ipr_wr && is_reg(ipr_idx, `DTF_IDX_PTBR);
   wire wr_perr = ipr_wr && is_reg(ipr_idx, `DTF_IDX_PERR);
   wire wr_ctrl = ipr_wr && is_reg(ipr_idx, `DTF_IDX_CTRL);
   wire wr_space = ipr_wr && is_reg(ipr_idx, `DTF_IDX_SPACE_ID);
   wire wr_mode = ipr_wr && is_reg(ipr_idx, `DTF_IDX_MODE);
   wire rd_entry = ipr_rd && is_reg(ipr_idx, `DTF_IDX_ENTRY);
   wire rd_faddr = ipr_rd && is_reg(ipr_idx, `DTF_IDX_FADDR);

   // ****************************************
   // Shadow, staging and control registers
   // ****************************************
   reg [63:0] entry_stage;
   reg [63:0] ptbr;
   reg [5:0] ctrl;
   wire [63:0] entry_hold;

   // Timeout reset is deliberately ignored everywhere in this block
   always @(posedge clk) begin
      if (rst) begin
         data_tlb_space_id_reg <= 7'h00;
         data_tlb_mode_reg <= 2'h0;
         entry_stage <= 64'h0;
         ptbr <= 64'h0;
         ctrl <= `DTF_CTRL_RESET;
         flat_pte_format_bit <= 1'b0;
      end else begin
         if (wr_space) begin
            data_tlb_space_id_reg <= ipr_wdata[6:0];
         end
         if (wr_mode) begin
            data_tlb_mode_reg <= ipr_wdata[1:0];
         end
         if (wr_entry) begin
            // Page valid bit dropped before staging
            entry_stage <= ipr_wdata & ~(64'h1 << `DTF_PTE_VALID_BIT);
         end
         if (wr_ptbr) begin
            ptbr <= ipr_wdata;
         end
         if (wr_ctrl) begin
            ctrl <= ipr_wdata[5:0];
            flat_pte_format_bit <= ipr_wdata[`DTF_CTRL_FLAT_BIT];
         end
      end
   end

   // ****************************************
   // Entry array
   // ****************************************
   dtf_entry_array u_array (
      .clk(clk),
      .rst(rst),
      .tag_wr(wr_tag),
      .tag_in(ipr_wdata[`DTF_TAG_MSB:`DTF_TAG_LSB]),
      .pte_in(entry_stage),
      .entry_rd(rd_entry),
      .entry_out(entry_hold),
      .look_req(look_req),
      .look_va(look_va),
      .look_hit(look_hit),
      .look_pte(look_pte)
   );

   // ****************************************
   // Fault capture
   // ****************************************
   // Lock and captured values have no reset; they persist across it
   reg fault_lock;
   reg [16:0] dstream_fault_status;
   reg [63:0] fault_address_latch;
   reg [63:0] formatted_fault_address;
   wire parity_any = |parity_err;
   wire capture = (mm_fault || tlb_miss_flag || parity_any) && !fault_lock;
   wire [63:0] next_form_std;
   wire [63:0] next_form_flat;

   // Undefined positions are tied to zero
   assign next_form_std = {ptbr[63:`DTF_FORM_STD_BASE_LSB], fault_va[`DTF_TAG_MSB:`DTF_TAG_LSB], 3'h0};
   assign next_form_flat = {ptbr[63:`DTF_FORM_FLAT_BASE_LSB], 8'h00,
                            fault_va[`DTF_FORM_FLAT_VA_MSB:`DTF_TAG_LSB], 3'h0};

   // Formatted value is frozen at capture so later base writes cannot disturb it
   always @(posedge clk) begin
      if (capture) begin
         dstream_fault_status <= {fault_opcode, fault_ra, bad_address_flag, tlb_miss_flag,
                                  write_fault_flag, read_fault, access_violation_flag, ref_write};
         fault_address_latch <= fault_va;
         formatted_fault_address <= flat_pte_format_bit ? next_form_flat : next_form_std;
      end
      if (capture) begin
         fault_lock <= 1'b1;
      end else if (rd_faddr) begin
         fault_lock <= 1'b0;
      end
   end

   // ****************************************
   // Parity status
   // ****************************************
   wire [5:0] perr_status;

   dtf_parity_status u_parity (
      .clk(clk),
      .perr_in(parity_err),
      .clr_wr(wr_perr),
      .clr_data(ipr_wdata[1:0]),
      .status(perr_status)
   );

   // ****************************************
   // Read path
   // ****************************************
   reg [63:0] next_rdata;

   always @* begin
      next_rdata = 64'h0;
      if (is_reg(ipr_idx, `DTF_IDX_HOLD)) begin
         next_rdata = entry_hold;
      end else if (is_reg(ipr_idx, `DTF_IDX_FSTAT)) begin
         next_rdata = {47'h0, dstream_fault_status};
      end else if (is_reg(ipr_idx, `DTF_IDX_FADDR)) begin
         next_rdata = fault_address_latch;
      end else if (is_reg(ipr_idx, `DTF_IDX_FORM)) begin
         next_rdata = formatted_fault_address;
      end else if (is_reg(ipr_idx, `DTF_IDX_PERR)) begin
         next_rdata = {58'h0, perr_status};
      end else if (is_reg(ipr_idx, `DTF_IDX_CTRL)) begin
         next_rdata = {58'h0, ctrl};
      end else begin
         // Entry register read and write-only registers answer zero
         next_rdata = 64'h0;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         ipr_rdata <= 64'h0;
         ipr_rvalid <= 1'b0;
      end else begin
         ipr_rvalid <= ipr_rd;
         ipr_rdata <= ipr_rd ? next_rdata : 64'h0;
      end
   end

endmodule
`default_nettype wire

// *** rtl/dtf_map.vh ***
// Register indices, field positions and widths for the data TLB fault block
`ifndef DTF_MAP_VH
`define DTF_MAP_VH

// ****************************************
// Register indices
// ****************************************
`define DTF_IDX_SPACE_ID 4'h0
`define DTF_IDX_MODE 4'h1
`define DTF_IDX_TAG 4'h2
`define DTF_IDX_ENTRY 4'h3
`define DTF_IDX_HOLD 4'h4
`define DTF_IDX_FSTAT 4'h5
`define DTF_IDX_FADDR 4'h6
`define DTF_IDX_FORM 4'h7
`define DTF_IDX_PTBR 4'h8
`define DTF_IDX_PERR 4'h9
`define DTF_IDX_CTRL 4'ha

// ****************************************
// Widths and reset values
// ****************************************
`define DTF_SPACE_ID_W 7
`define DTF_MODE_W 2
`define DTF_TAG_W 30
`define DTF_ENTRIES 64
`define DTF_PTR_W 6
`define DTF_CTRL_W 6
`define DTF_CTRL_RESET 6'h00
`define DTF_PTR_RESET 6'h00

// ****************************************
// Field positions
// ****************************************
`define DTF_CTRL_FLAT_BIT 1
`define DTF_PTE_VALID_BIT 0
`define DTF_FSTAT_W 17
`define DTF_TAG_MSB 42
`define DTF_TAG_LSB 13
`define DTF_FORM_STD_BASE_LSB 33
`define DTF_FORM_FLAT_BASE_LSB 30
`define DTF_FORM_FLAT_VA_MSB 31
`define DTF_PERR_SEO_BIT 0
`define DTF_PERR_LOCK_BIT 1

`endif

// *** rtl/dtf_parity_status.v ***
// Data cache parity error status with lock and second-error flag
`timescale 1ns/10ps
`default_nettype none
`include "dtf_map.vh"

module dtf_parity_status (
   input wire clk,
   input wire [3:0] perr_in,
   input wire clr_wr,
   input wire [1:0] clr_data,
   output wire [5:0] status
);

   // ****************************************
   // Status storage
   // ****************************************
   // No reset here: the status survives reset by design
   reg second_error_flag;
   reg lock;
   reg [3:0] banks;
   wire err_any = |perr_in;
   wire clr_lock = clr_wr && clr_data[`DTF_PERR_LOCK_BIT];
   wire clr_seo = clr_wr && clr_data[`DTF_PERR_SEO_BIT];

   always @(posedge clk) begin
      if (err_any && (!lock || clr_lock)) begin
         // New error beats a same-cycle lock clear
         banks <= perr_in;
         lock <= 1'b1;
      end else if (clr_lock) begin
         banks <= 4'h0;
         lock <= 1'b0;
      end
      // Both pipes in one cycle arrive together, so they set it only if the lock is already held
      if (err_any && lock && !clr_lock) begin
         second_error_flag <= 1'b1;
      end else if (clr_seo) begin
         second_error_flag <= 1'b0;
      end
   end

   assign status = {banks, lock, second_error_flag};

endmodule
`default_nettype wire

// *** rtl/dtf_entry_array.v ***
// Data TLB entry storage with fill pointer, readback and lookup
`timescale 1ns/10ps
`default_nettype none
`include "dtf_map.vh"

module dtf_entry_array (
   input wire clk,
   input wire rst,
   input wire tag_wr,
   input wire [29:0] tag_in,
   input wire [63:0] pte_in,
   input wire entry_rd,
   output reg [63:0] entry_out,
   input wire look_req,
   input wire [29:0] look_va,
   output reg look_hit,
   output reg [63:0] look_pte
);

   // ****************************************
   // Storage and pointers
   // ****************************************
   reg [5:0] ptr;
   reg [5:0] last_used;
   reg used_vld;
   reg [63:0] valid;
   reg [29:0] tag_mem [0:63];
   reg [63:0] pte_mem [0:63];
   wire [63:0] match;
   wire [5:0] fill_idx;
   wire [5:0] hit_idx;

   function [5:0] first_set;
      input [63:0] v;
      integer i;
      begin
         first_set = 6'h00;
         for (i = 63; i >= 0; i = i - 1) begin
            if (v[i]) begin
               first_set = i[5:0];
            end
         end
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < `DTF_ENTRIES; g = g + 1) begin : g_match
         assign match[g] = valid[g] && (tag_mem[g] == look_va);
      end
   endgenerate

   assign hit_idx = first_set(match);
   // Skip the most recently hit entry so a live mapping is not evicted
   // Before any hit nothing is protected, so all 64 entries fill in turn
   assign fill_idx = (used_vld && (ptr == last_used)) ? ptr + 6'h01 : ptr;

   // ****************************************
   // Fill, readback, lookup
   // ****************************************
   always @(posedge clk) begin
      if (tag_wr) begin
         tag_mem[fill_idx] <= tag_in;
         pte_mem[fill_idx] <= pte_in;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         ptr <= `DTF_PTR_RESET;
         valid <= 64'h0;
         last_used <= 6'h3f;
         used_vld <= 1'b0;
         entry_out <= 64'h0;
         look_hit <= 1'b0;
         look_pte <= 64'h0;
      end else begin
         look_hit <= look_req && (|match);
         // A miss answers zero rather than a stale entry
         look_pte <= (look_req && (|match)) ? pte_mem[hit_idx] : 64'h0;
         if (look_req && (|match)) begin
            last_used <= hit_idx;
            used_vld <= 1'b1;
         end
         if (tag_wr) begin
            valid[fill_idx] <= 1'b1;
            ptr <= fill_idx + 6'h01;
         end else if (entry_rd) begin
            entry_out <= pte_mem[ptr];
            ptr <= ptr + 6'h01;
         end
      end
   end

endmodule
`default_nettype wire

// *** verification/dtf_tlb_fault_regs_assertions.sv ***
// Port checks for the data TLB fault register block
`timescale 1ns/10ps
`default_nettype none
module dtf_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic ipr_wr,
   input wire logic ipr_rd,
   input wire logic [3:0] ipr_idx,
   input wire logic [63:0] ipr_wdata,
   input wire logic [63:0] ipr_rdata,
   input wire logic ipr_rvalid,
   input wire logic mm_fault,
   input wire logic [3:0] parity_err,
   input wire logic [6:0] data_tlb_space_id_reg,
   input wire logic [1:0] data_tlb_mode_reg,
   input wire logic flat_pte_format_bit
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_at(logic [3:0] i);
      ipr_rd && ipr_idx == i;
   endsequence
   // Two error cycles with no clear in between
   sequence two_errs;
      (parity_err != 4'h0 && !ipr_wr) [*2];
   endsequence
   // Lock is certain after the event, so two reads must agree
   sequence locked_reads;
      mm_fault && !(ipr_rd && ipr_idx == 4'h6) ##1 rd_at(4'h5) ##1 rd_at(4'h5);
   endsequence
   rd_pulse_a: assert property (ipr_rd |=> ipr_rvalid) else $error("read got no answer");
   entry_zero_a: assert property (rd_at(4'h3) |=> ipr_rdata == 64'h0) else $error("entry read not zero");
   hold_valid_a: assert property (rd_at(4'h4) |=> !ipr_rdata[0]) else $error("valid bit kept");
   stat_pad_a: assert property (rd_at(4'h5) |=> ipr_rdata[63:17] == 47'h0) else $error("status pad");
   form_pad_a: assert property (rd_at(4'h7) |=> ipr_rdata[2:0] == 3'h0) else $error("form pad");
   perr_pad_a: assert property (rd_at(4'h9) |=> ipr_rdata[63:6] == 58'h0) else $error("parity pad");
   seo_set_a: assert property (two_errs ##1 rd_at(4'h9) |=> ipr_rdata[1:0] == 2'b11)
      else $error("second error lost");
   frozen_stat_a: assert property (locked_reads |=> ipr_rdata == $past(ipr_rdata))
      else $error("status moved while locked");
   reset_clear_a: assert property ($fell(rst) |-> data_tlb_space_id_reg == 7'h0 &&
      data_tlb_mode_reg == 2'h0 && !flat_pte_format_bit) else $error("shadow not reset");
   flat_write_a: assert property (ipr_wr && ipr_idx == 4'ha |=>
      flat_pte_format_bit == $past(ipr_wdata[1])) else $error("flat bit not written");
endmodule
bind dtf_tlb_fault_regs dtf_checker i_chk (.clk, .rst, .ipr_wr, .ipr_rd, .ipr_idx, .ipr_wdata, .ipr_rdata,
   .ipr_rvalid, .mm_fault, .parity_err, .data_tlb_space_id_reg, .data_tlb_mode_reg, .flat_pte_format_bit);
`default_nettype wire

// *** verification/dtf_core_model.sv ***
// Processor core model issuing register transfers
`timescale 1ns/10ps
`default_nettype none
module dtf_core_model (
   input wire logic clk,
   output logic wr,
   output logic rd,
   output logic [3:0] idx,
   output logic [63:0] wdata,
   input wire logic [63:0] rdata,
   input wire logic rvalid
);
   logic [63:0] last;
   initial {wr, rd, idx, wdata} = 70'h0;
   always @(posedge clk) if (rvalid) last <= rdata;
   // Strobes stay up so a following transfer can go back to back
   // Every task starts one step after an edge and ends the same way
   task op(input logic w, input logic [3:0] i, input logic [63:0] d);
      {wr, rd, idx} = {w, !w, i};
      wdata = w ? d : ~wdata;
      @(posedge clk);
      #1;
   endtask
   // Released bus shows changing junk, not the last value
   task idle;
      {wr, rd, idx, wdata} = {2'b00, ~idx, ~wdata};
      @(posedge clk);
      #1;
   endtask
   task get(input logic [3:0] i, output logic [63:0] d);
      op(1'b0, i, 64'h0);
      idle;
      d = last;
   endtask
   task shadow(input logic [6:0] s, input logic [1:0] m);
      op(1'b1, 4'h0, {s, 50'h0, s});
      op(1'b1, 4'h1, {59'h0, m, 1'b0, m});
   endtask
endmodule
`default_nettype wire

// *** verification/test_dtf_tlb_fault_regs.sv ***
// Random and directed bench for the data TLB fault register block
`timescale 1ns/10ps
`default_nettype none
module test_dtf_tlb_fault_regs;
   logic clk, rst, tmo, mmf, wr, rd, rvalid, flat, lr, lhit;
   logic [29:0] lva;
   logic [29:0] tg [0:63];
   logic [63:0] lpte;
   logic [16:0] st, es;
   logic [63:0] va, eva, base, eb, wdata, rdata, got;
   logic [3:0] perr, idx;
   logic [6:0] sid, s;
   logic [1:0] cm, m;
   logic [63:0] pte [0:63];
   int n_mismatch, check_count, seed, k;
   dtf_tlb_fault_regs i_dtf_tlb_fault_regs (.clk(clk), .rst(rst), .timeout_rst(tmo), .ipr_wr(wr),
      .ipr_rd(rd), .ipr_idx(idx), .ipr_wdata(wdata), .ipr_rdata(rdata), .ipr_rvalid(rvalid),
      .mm_fault(mmf), .tlb_miss_flag(st[4]), .ref_write(st[0]), .access_violation_flag(st[1]),
      .read_fault(st[2]), .write_fault_flag(st[3]), .bad_address_flag(st[5]), .fault_ra(st[10:6]),
      .fault_opcode(st[16:11]), .fault_va(va), .parity_err(perr), .look_req(lr), .look_va(lva),
      .look_hit(lhit), .look_pte(lpte), .data_tlb_space_id_reg(sid), .data_tlb_mode_reg(cm),
      .flat_pte_format_bit(flat));
   dtf_core_model core (.clk(clk), .wr(wr), .rd(rd), .idx(idx), .wdata(wdata), .rdata(rdata),
      .rvalid(rvalid));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Timeout reset toggles freely and must change nothing
   always @(posedge clk) tmo <= #1 va[7] ^ st[2];
   task chk(input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t exp %h got %h", $time, e, g);
      end
   endtask
   task rdc(input logic [3:0] i, input logic [63:0] e);
      core.get(i, got);
      chk(e, got);
   endtask
   // Lookup result stands one cycle; it is looked at one step after its edge
   task look(input logic [29:0] a, input logic eh, input logic [63:0] ep);
      {lr, lva} = {1'b1, a};
      @(posedge clk);
      #1 lr = 1'b0;
      chk({63'h0, eh}, {63'h0, lhit});
      chk(ep, lpte);
      @(posedge clk);
      #1;
   endtask
   task ev(input logic f, input logic miss, input logic [3:0] p);
      {mmf, perr} = {f, p};
      st = 17'($random(seed));
      st[4] = miss;
      va = {$random(seed), $random(seed)};
      @(posedge clk);
      #1;
   endtask
   function automatic logic [63:0] form(input logic [63:0] b, input logic [63:0] v, input logic f);
      if (f) return {b[63:30], 8'h0, v[31:13], 3'h0};
      return {b[63:33], v[42:13], 3'h0};
   endfunction
   task give_verdict;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      seed = 32'hc02b;
      {rst, mmf, perr, st, va, lr, lva} = {2'b10, 4'h0, 17'h0, 64'h0, 1'b0, 30'h0};
      n_mismatch = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      #1 rst = 1'b0;
      core.get(4'h6, got);
      core.op(1'b1, 4'h9, 64'h3);
      s = 7'($random(seed));
      m = 2'($random(seed));
      core.shadow(s, m);
      core.idle;
      chk({57'h0, s}, {57'h0, sid});
      chk({62'h0, m}, {62'h0, cm});
      // ****
      // Entry fill and readback
      // ****
      for (k = 0; k < 64; k++) begin
         pte[k] = {$random(seed), $random(seed)};
         tg[k] = 30'($random(seed));
         core.op(1'b1, 4'h3, pte[k]);
         core.op(1'b1, 4'h2, {21'h0, tg[k], 13'h0});
      end
      rdc(4'h3, 64'h0);
      for (k = 0; k < 64; k++) begin
         rdc(4'h3, 64'h0);
         rdc(4'h4, pte[(k + 1) % 64] & ~64'h1);
      end
      core.op(1'b1, 4'h3, ~pte[0]);
      rdc(4'h4, pte[0] & ~64'h1);
      // Pointer rests on entry 1; a hit there makes the next fill take entry 2
      look(tg[1], 1'b1, pte[1] & ~64'h1);
      core.op(1'b1, 4'h2, {21'h0, ~tg[2], 13'h0});
      core.idle;
      look(tg[1], 1'b1, pte[1] & ~64'h1);
      look(tg[2], 1'b0, 64'h0);
      look(~tg[2], 1'b1, ~pte[0] & ~64'h1);
      // ****
      // Parity status
      // ****
      for (k = 0; k < 4; k++) begin
         ev(1'b0, 1'b0, 4'h1 << k);
         ev(1'b0, 1'b0, 4'hf);
         rdc(4'h9, {58'h0, 4'h1 << k, 2'b11});
         ev(1'b0, 1'b0, 4'h0);
         core.op(1'b1, 4'h9, 64'h1);
         rdc(4'h9, {58'h0, 4'h1 << k, 2'b10});
         core.op(1'b1, 4'h9, 64'h2);
         rdc(4'h9, 64'h0);
      end
      ev(1'b0, 1'b0, 4'h3);
      ev(1'b0, 1'b0, 4'h0);
      rdc(4'h9, 64'h0e);
      core.op(1'b1, 4'h9, 64'h3);
      core.get(4'h6, got);
      // ****
      // Fault capture and lock
      // ****
      base = {$random(seed), $random(seed)};
      core.op(1'b1, 4'h8, base);
      for (k = 0; k < 3; k++) begin
         eb = base;
         core.op(1'b1, 4'ha, {62'h0, k[0], 1'b0});
         core.idle;
         ev(k == 0, k == 1, {3'h0, k == 2});
         {es, eva} = {st, va};
         ev(1'b1, 1'b1, 4'h2);
         core.op(1'b0, 4'h5, 64'h0);
         rdc(4'h5, {47'h0, es});
         base = {$random(seed), $random(seed)};
         core.op(1'b1, 4'h8, base);
         core.idle;
         ev(1'b0, 1'b0, 4'h0);
         rdc(4'h7, form(eb, eva, k[0]));
         rdc(4'h6, eva);
         core.op(1'b1, 4'h9, 64'h3);
      end
      core.idle;
      ev(1'b1, 1'b0, 4'h0);
      {es, eva} = {st, va};
      ev(1'b0, 1'b0, 4'h0);
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      // Lock must survive reset, so this event is ignored
      ev(1'b1, 1'b1, 4'h0);
      rdc(4'h5, {47'h0, es});
      rdc(4'h6, eva);
      rdc(4'h3, 64'h0);
      rdc(4'h4, pte[0] & ~64'h1);
      look(tg[1], 1'b0, 64'h0);
      give_verdict;
   end
endmodule
`default_nettype wire
